/* File: pcg_regs.vh */
// Purpose: register map and field constants for the clock gate and pll control block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes:   printed offset f02e5h is not a multiple of four, so offsets are indices
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// register indices as printed, byte address is four times these
`define PCG_IDX_PER_CLK_EN     20'hf00f0
`define PCG_IDX_PLL_CTRL       20'hf02e5
// byte addresses of the two registers
`define PCG_ADDR_PER_CLK_EN    22'h3c03c0
`define PCG_ADDR_PLL_CTRL      22'h3c0b94
`define PCG_ADDR_W             22

// reset values
`define PCG_PER_CLK_EN_RST     8'h00
`define PCG_PLL_CTRL_RST       8'h00

// writable masks (reserved bits read zero)
`define PCG_PER_CLK_EN_MASK    8'hbd
`define PCG_PLL_CTRL_MASK      8'h07

// peripheral enable field positions
`define PCG_BIT_RTC            7
`define PCG_BIT_ADC            5
`define PCG_BIT_I2C            4
`define PCG_BIT_SAU1           3
`define PCG_BIT_SAU0           2
`define PCG_BIT_TAU            0

// pll control field positions
`define PCG_BIT_PREDIV         2
`define PCG_BIT_MULT           1
`define PCG_BIT_RUN            0

// pll multiplication factors before and after the final halving
`define PCG_MULT_LO            5'd12
`define PCG_MULT_HI            5'd16
`define PCG_EFF_MULT_LO        4'd6
`define PCG_EFF_MULT_HI        4'd8

// main clock source select codes
`define PCG_SRC_OSC            1'b0
`define PCG_SRC_PLL            1'b1
// highest allowed main clock source frequency in mhz
`define PCG_MAIN_MAX_MHZ       24

`endif

/* File: pcg_clock_gate.v */
// Purpose: peripheral clock-enable register and pll control register with apb access
// Assumes: single clock pclk at 125 mhz, async active-low reset presetn
// Notes:   clock gating is latch-free enable style; pll is modelled by its control outputs
//
// Contract
// - 8-bit peripheral enable register, reset 00h
// - rtc enable low stops clock, blocks writes
// - enable high supplies clock, allows read/write
// - adc enable low stops clock, holds reset
// - 8-bit pll control register, reset 00h
// - predivide bit halves pll reference clock
// - multiply select picks 12 or 16
// - final stage halves pll output
// - run bit low stops pll output
// - main source osc/1..8 or pll/2..8, max 24mhz
`timescale 1ns/1ps
`include "pcg_regs.vh"

module pcg_clock_gate (
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pcg_ce,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // peripheral clock enables (glitch-free gate enables for fclk)
    output wire        rtc_clk_en,
    output wire        adc_clk_en,
    output wire        i2c_clk_en,
    output wire        sau0_clk_en,
    output wire        sau1_clk_en,
    output wire        tau_clk_en,
    // peripheral register write permission
    output wire        rtc_wr_allow,
    output wire        adc_wr_allow,
    output wire        i2c_wr_allow,
    output wire        sau0_wr_allow,
    output wire        sau1_wr_allow,
    output wire        tau_wr_allow,
    // converter held in reset, active low
    output wire        adc_rst_n,
    // pll controls
    output wire        pll_ref_div2,
    output wire [4:0]  pll_vco_mult,
    output wire [3:0]  pll_eff_mult,
    output wire        pll_run,
    output wire        pll_out_en,
    // main clock source selection from outside control
    input  wire        main_src_sel,
    input  wire [1:0]  main_div_sel,
    output wire [3:0]  main_div_ratio,
    output wire        main_div_illegal
);

    // register storage
    reg  [7:0]  per_clk_en_q;                   // peripheral clock enable register
    reg  [7:0]  per_clk_en_d;
    reg  [7:0]  pll_ctrl_q;                     // pll control register
    reg  [7:0]  pll_ctrl_d;

    // decode: apb byte address compared in full, 22 low bits matched and upper bits zero
    wire        hit_per;                        // peripheral enable selected
    wire        hit_pll;                        // pll control selected
    wire        wr_take;                        // write accepted at this edge
    wire        acc;                            // access phase

    assign acc     = psel & penable;
    assign hit_per = (paddr[`PCG_ADDR_W-1:0] == `PCG_ADDR_PER_CLK_EN) && (paddr[31:`PCG_ADDR_W] == 10'h000);
    assign hit_pll = (paddr[`PCG_ADDR_W-1:0] == `PCG_ADDR_PLL_CTRL) && (paddr[31:`PCG_ADDR_W] == 10'h000);
    assign wr_take = acc & pwrite & pcg_ce & pstrb[0];

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~(hit_per | hit_pll);

    // next values: only byte lane 0 carries data, reserved bits forced zero
    always @* begin
        per_clk_en_d = per_clk_en_q;
        pll_ctrl_d   = pll_ctrl_q;
        if (wr_take && hit_per) begin
            per_clk_en_d = pwdata[7:0] & `PCG_PER_CLK_EN_MASK;
        end
        if (wr_take && hit_pll) begin
            pll_ctrl_d = pwdata[7:0] & `PCG_PLL_CTRL_MASK;
        end
    end

    // register update; clock enable low freezes everything
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_clk_en_q <= `PCG_PER_CLK_EN_RST;
            pll_ctrl_q   <= `PCG_PLL_CTRL_RST;
        end else if (pcg_ce) begin
            per_clk_en_q <= per_clk_en_d;
            pll_ctrl_q   <= pll_ctrl_d;
        end
    end

    // read data registered at the end of the setup phase; reserved bits read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (pcg_ce && psel && !penable && !pwrite) begin
            if (hit_per) begin
                prdata <= {24'h000000, per_clk_en_q};
            end else if (hit_pll) begin
                prdata <= {24'h000000, pll_ctrl_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // clock supply follows each enable bit
    assign rtc_clk_en  = per_clk_en_q[`PCG_BIT_RTC];
    assign adc_clk_en  = per_clk_en_q[`PCG_BIT_ADC];
    assign i2c_clk_en  = per_clk_en_q[`PCG_BIT_I2C];
    assign sau1_clk_en = per_clk_en_q[`PCG_BIT_SAU1];
    assign sau0_clk_en = per_clk_en_q[`PCG_BIT_SAU0];
    assign tau_clk_en  = per_clk_en_q[`PCG_BIT_TAU];

    // write permission: reads stay open, writes blocked while disabled
    assign rtc_wr_allow  = per_clk_en_q[`PCG_BIT_RTC];
    assign adc_wr_allow  = per_clk_en_q[`PCG_BIT_ADC];
    assign i2c_wr_allow  = per_clk_en_q[`PCG_BIT_I2C];
    assign sau1_wr_allow = per_clk_en_q[`PCG_BIT_SAU1];
    assign sau0_wr_allow = per_clk_en_q[`PCG_BIT_SAU0];
    assign tau_wr_allow  = per_clk_en_q[`PCG_BIT_TAU];

    // converter held in reset while its enable is low; rtc core keeps running
    assign adc_rst_n = per_clk_en_q[`PCG_BIT_ADC];

    // pll reference predivide and multiplier selection
    assign pll_ref_div2 = pll_ctrl_q[`PCG_BIT_PREDIV];
    assign pll_vco_mult = pll_ctrl_q[`PCG_BIT_MULT] ? `PCG_MULT_HI : `PCG_MULT_LO;
    // final halving stage gives the effective factor
    assign pll_eff_mult = pll_ctrl_q[`PCG_BIT_MULT] ? `PCG_EFF_MULT_HI : `PCG_EFF_MULT_LO;
    // run bit starts oscillation and output
    assign pll_run      = pll_ctrl_q[`PCG_BIT_RUN];
    assign pll_out_en   = pll_ctrl_q[`PCG_BIT_RUN];

    // main source divider: osc allows 1,2,4,8; pll allows 2,4,8 only
    assign main_div_ratio   = 4'h1 << main_div_sel;
    // pll/1 would exceed the main source ceiling, flagged as illegal
    assign main_div_illegal = (main_src_sel == `PCG_SRC_PLL) && (main_div_sel == 2'b00);

endmodule

/* File: pcg_clock_gate_checker.sv */
// Purpose: port assertions for the clock gate and pll control block
// Assumes: one clock pclk, async reset presetn active low
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_clock_gate_checker (
    // clock, reset and bus
    input wire logic        pclk, presetn, pcg_ce, psel, penable, pwrite, pslverr,
    input wire logic [31:0] paddr, pwdata,
    input wire logic [3:0]  pstrb,
    // gates and pll controls
    input wire logic        rtc_clk_en, rtc_wr_allow, adc_clk_en, adc_wr_allow, adc_rst_n,
    input wire logic        pll_ref_div2, pll_run, pll_out_en,
    input wire logic [4:0]  pll_vco_mult,
    input wire logic [3:0]  pll_eff_mult, main_div_ratio,
    input wire logic [1:0]  main_div_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write that lands, one per register
    sequence per_wr;
        psel && penable && pwrite && pcg_ce && pstrb[0] && paddr == {10'h0, `PCG_ADDR_PER_CLK_EN};
    endsequence
    sequence pll_wr;
        psel && penable && pwrite && pcg_ce && pstrb[0] && paddr == {10'h0, `PCG_ADDR_PLL_CTRL};
    endsequence
    chk_per_write:
    assert property (per_wr |=> rtc_clk_en == $past(pwdata[7]) && adc_clk_en == $past(pwdata[5]))
        else $error("peripheral enable write did not land");
    chk_pll_write:
    assert property (pll_wr |=> pll_ref_div2 == $past(pwdata[2]) && pll_vco_mult == ($past(pwdata[1]) ? 5'd16 : 5'd12))
        else $error("pll control write did not land");
    chk_rtc_gate:
    assert property (rtc_wr_allow == rtc_clk_en) else $error("rtc write permission differs from its gate");
    chk_adc_reset:
    assert property (!adc_clk_en |-> !adc_rst_n && !adc_wr_allow) else $error("adc not held while gated");
    chk_mult_halved:
    assert property (pll_vco_mult == {pll_eff_mult, 1'b0}) else $error("effective multiplier not half");
    chk_run_output:
    assert property (pll_out_en == pll_run) else $error("pll output differs from run bit");
    chk_main_divider:
    assert property (main_div_ratio == 4'd1 << main_div_sel) else $error("main divide ratio wrong");
    chk_unmapped_err:
    assert property (psel && penable && paddr != {10'h0, `PCG_ADDR_PER_CLK_EN}
        && paddr != {10'h0, `PCG_ADDR_PLL_CTRL} |-> pslverr) else $error("unmapped access not flagged");
    chk_ce_freeze:
    assert property (!pcg_ce |=> $stable({pll_run, pll_ref_div2, rtc_clk_en})) else $error("state moved while frozen");
endmodule
bind pcg_clock_gate pcg_clock_gate_checker u_chk (.*);

/* File: pcg_clock_gate_tb.sv */
// Purpose: directed apb tests of the clock gate and pll control block
// Assumes: the bench waits for pready under a bounded count
// Notes:   expected values come from the bit map, never from outputs
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_clock_gate_tb;
    // bus and control inputs, valued at time zero
    logic pclk = 0, presetn = 0, pcg_ce = 1, psel = 0, penable = 0, pwrite = 0, main_src_sel = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 4'hf, pll_eff_mult, main_div_ratio;
    logic [1:0]  main_div_sel = 0;
    logic [4:0]  pll_vco_mult;
    // design outputs
    logic pready, pslverr, slv, rtc_clk_en, adc_clk_en, i2c_clk_en, sau0_clk_en, sau1_clk_en, tau_clk_en;
    logic rtc_wr_allow, adc_wr_allow, i2c_wr_allow, sau0_wr_allow, sau1_wr_allow, tau_wr_allow;
    logic adc_rst_n, pll_ref_div2, pll_run, pll_out_en, main_div_illegal;
    int failures = 0, compares = 0, cyc = 0;
    // bits 6 and 1 stay zero in every pattern, as software must keep them
    logic [7:0] pv [5] = '{8'h00, 8'hbd, 8'h21, 8'h88, 8'h14};
    wire [12:0] gates = {rtc_clk_en, adc_clk_en, i2c_clk_en, sau1_clk_en, sau0_clk_en, tau_clk_en, rtc_wr_allow,
                         adc_wr_allow, i2c_wr_allow, sau1_wr_allow, sau0_wr_allow, tau_wr_allow, adc_rst_n};
    localparam logic [31:0] A_PER = {10'h0, `PCG_ADDR_PER_CLK_EN};
    localparam logic [31:0] A_PLL = {10'h0, `PCG_ADDR_PLL_CTRL};
    pcg_clock_gate DUT (.*);
    always #4 pclk = ~pclk;
    // hang guard, far above the roughly 110 cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; idle edge after it so psel never toggles in one step
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) failures++;
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, A_PER, 0);
        cmp("per reset", 0, rd);
        apb(0, A_PLL, 0);
        cmp("pll reset", 0, rd);
        // each enable pattern: gates, permissions and adc reset follow it
        foreach (pv[k]) begin
            apb(1, A_PER, {24'h0, pv[k]});
            cmp("gates", {19'h0, {2{pv[k][7], pv[k][5:2], pv[k][0]}}, pv[k][5]}, {19'h0, gates});
            apb(0, A_PER, 0);
            cmp("per readback", {24'h0, pv[k] & 8'hbd}, rd);
        end
        // every pll setting, reserved bits written zero as software must
        for (int i = 0; i < 8; i++) begin
            apb(1, A_PLL, {29'h0, i[2:0]});
            cmp("pll outputs", {i[2], i[1] ? 9'h108 : 9'h0c6, i[0], i[0]},
                {pll_ref_div2, pll_vco_mult, pll_eff_mult, pll_run, pll_out_en});
            apb(0, A_PLL, 0);
            cmp("pll readback", i, rd);
        end
        // refused writes: frozen, no byte lane, unmapped
        pcg_ce <= 1'b0;
        apb(1, A_PLL, 0);
        pcg_ce <= 1'b1;
        pstrb <= 4'h0;
        apb(1, A_PLL, 0);
        pstrb <= 4'hf;
        apb(1, 32'h10, 32'hff);
        cmp("slverr", 1, slv);
        apb(0, A_PLL, 0);
        cmp("pll kept", 7, rd);
        // main source divider over both sources and all ratios
        for (int s = 0; s < 8; s++) begin
            main_src_sel <= s[2];
            main_div_sel <= s[1:0];
            @(posedge pclk);
            cmp("main div", {s[2] && s[1:0] == 0, 4'd1 << s[1:0]}, {main_div_illegal, main_div_ratio});
        end
        print_verdict();
    end
endmodule
